// *** hdl/sss_pkg.sv ***
// Purpose: shared constants and types for the scan stream sequencer
// Assumes: one clock, word registers on an AHB-Lite slave
// Notes: byte addresses, one aligned word per register
package sss_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] ADDR_CTRL = 16'h0000;
  localparam logic [15:0] ADDR_STATUS = 16'h0004;
  localparam logic [15:0] ADDR_INTERVAL = 16'h0008;
  localparam logic [15:0] ADDR_LIST_LEN = 16'h000C;
  localparam logic [15:0] ADDR_RES = 16'h0010;
  localparam logic [15:0] ADDR_FIFO_DATA = 16'h0014;
  localparam logic [15:0] ADDR_FIFO_COUNT = 16'h0018;
  localparam logic [15:0] ADDR_CR_CHAN = 16'h001C;
  localparam logic [15:0] ADDR_CR_DATA = 16'h0020;
  localparam logic [15:0] ADDR_SAMPLE_WORD = 16'h0024;
  localparam logic [15:0] ADDR_LIST_BASE = 16'h0100;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_CLR_OVF_BIT = 2;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_OVF_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_RES_BAD_BIT = 3;
  localparam int STAT_CR_DONE_BIT = 4;
  localparam logic [31:0] INTERVAL_RESET = 32'h0000_0064;
  localparam logic [3:0] RES_HI_MIN = 4'h9;
  localparam logic [3:0] RES_HI_MAX = 4'hC;
  localparam logic [31:0] ERR_WORD = 32'hDEAD_0000;
  typedef enum logic [1:0] {SSS_IDLE, SSS_WAIT, SSS_SAMPLE} sss_state_type;
endpackage

// *** hdl/sss_adc_if.sv ***
// Purpose: request and answer wires to the analog input system
// Assumes: one conversion in flight at a time
// Notes: data valid for one cycle with done
`timescale 1ns/10ps
interface sss_adc_if #(parameter int CW = 8, parameter int DW = 16);
  logic req;
  logic [CW-1:0] chan;
  logic busy;
  logic done;
  logic [DW-1:0] data;
  modport master (output req, output chan, input busy, input done, input data);
  modport slave (input req, input chan, output busy, output done, output data);
endinterface

// *** hdl/sss_arbiter.sv ***
// Purpose: shares the analog input system between stream and command reads
// Assumes: the stream owns it outright while running
// Notes: command reads while streaming are dropped and flagged
`timescale 1ns/10ps
module sss_arbiter #(parameter int CW = 8, parameter int DW = 16) (
  input wire clk,
  input wire reset_n,
  input wire running,
  input wire str_req,
  input wire [CW-1:0] str_chan,
  input wire cr_req,
  input wire [CW-1:0] cr_chan,
  output logic cr_refused,
  sss_adc_if.master adc
);
  wire pass_cr = cr_req && !running;
  assign adc.req = running ? str_req : pass_cr;
  assign adc.chan = running ? str_chan : cr_chan;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cr_refused <= 1'b0;
    end else begin
      cr_refused <= cr_req && running;
    end
  end
endmodule

// *** hdl/sss_top.sv ***
// Purpose: scan stream sequencer with AHB-Lite register access
// Assumes: analog system answers one request with one done pulse
// Notes: samples wait in an on-chip buffer until read
// How it works
// - each register is read-only, write-only or read-write and honoured so
// - all settings and data reached the same way, by address only
// - host sends a command, device gives exactly one response
// - after reset command-response only; stream idle until started
// - stream scans the channel list paced by own hardware timer
// - scans start one programmed interval apart, start to start
// - samples in one scan taken back to back, no gap
// - stream samples held in device buffer until host reads them
// - resolution 9 to 12 refused for streaming
// - register access keeps working while streaming; interval, list length, resolution and list writes ignored while running
// - stream owns analog inputs; command reads of them refused
// - zero-based addresses across one 0 to 65535 map
// - wide values most significant word first, bytes MSB first
//
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module sss_top #(
  parameter int LIST_DEPTH = 16,
  parameter int FIFO_DEPTH = 64,
  parameter int CW = 8,
  parameter int DW = 16
) (
  input wire CLK,
  input wire RESET_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic ADC_REQ,
  output logic [CW-1:0] ADC_CHAN,
  input wire ADC_BUSY,
  input wire ADC_DONE,
  input wire [DW-1:0] ADC_DATA
);
  localparam int LAW = $clog2(LIST_DEPTH);
  localparam int FAW = $clog2(FIFO_DEPTH);
  // buffer pointers wrap by themselves, so the depth must be a power of two
  if (LIST_DEPTH < 2 || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 ||
      DW > 32 || CW > 16) begin
    $error("sss_top: unsupported parameter values");
  end

  // ****************************************
  // bus address phase capture
  // ****************************************
  logic wr_pend;
  logic rd_pend;
  logic [15:0] pend_addr;
  wire [15:0] bus_addr = HADDR[15:0];
  wire take = HSEL && HREADY && HTRANS[1];
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      pend_addr <= 16'h0000;
    end else begin
      wr_pend <= take && HWRITE;
      rd_pend <= take && !HWRITE;
      if (take) begin
        pend_addr <= bus_addr;
      end
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ****************************************
  // decode
  // ****************************************
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction
  wire in_list = (pend_addr >= sss_pkg::ADDR_LIST_BASE) &&
    (pend_addr < sss_pkg::ADDR_LIST_BASE + 16'(LIST_DEPTH * 4));
  wire [LAW-1:0] list_idx = LAW'(pend_addr[15:2] - sss_pkg::ADDR_LIST_BASE[15:2]);
  wire w_ctrl = wr_pend && hit(pend_addr, sss_pkg::ADDR_CTRL);
  wire w_int = wr_pend && hit(pend_addr, sss_pkg::ADDR_INTERVAL);
  wire w_len = wr_pend && hit(pend_addr, sss_pkg::ADDR_LIST_LEN);
  wire w_res = wr_pend && hit(pend_addr, sss_pkg::ADDR_RES);
  wire w_cr = wr_pend && hit(pend_addr, sss_pkg::ADDR_CR_CHAN);
  wire w_list = wr_pend && in_list;
  wire r_fifo = rd_pend && hit(pend_addr, sss_pkg::ADDR_FIFO_DATA);

  // ****************************************
  // control registers
  // ****************************************
  logic running;
  logic overflow;
  logic refused;
  logic res_bad;
  logic cr_done;
  logic [31:0] interval;
  logic [LAW:0] list_len;
  logic [3:0] res_index;
  logic [CW-1:0] list_mem [LIST_DEPTH];
  logic [DW-1:0] cr_data;
  logic [15:0] sample_lo;
  logic cr_req;
  logic cr_refused;
  wire start_cmd = w_ctrl && HWDATA[sss_pkg::CTRL_START_BIT];
  wire stop_cmd = w_ctrl && HWDATA[sss_pkg::CTRL_STOP_BIT];
  wire clr_ovf = w_ctrl && HWDATA[sss_pkg::CTRL_CLR_OVF_BIT];
  wire res_hi = (res_index >= sss_pkg::RES_HI_MIN) && (res_index <= sss_pkg::RES_HI_MAX);
  wire start_ok = start_cmd && !res_hi && (list_len != '0);
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      interval <= sss_pkg::INTERVAL_RESET;
      list_len <= '0;
      res_index <= 4'h0;
    end else begin
      if (w_int && !running) begin
        interval <= HWDATA;
      end
      if (w_len && !running && HWDATA <= 32'(LIST_DEPTH)) begin
        list_len <= (LAW + 1)'(HWDATA);
      end
      if (w_res && !running) begin
        res_index <= HWDATA[3:0];
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (w_list && !running) begin
      list_mem[list_idx] <= HWDATA[CW-1:0];
    end
  end

  // ****************************************
  // scan sequencer
  // ****************************************
  sss_pkg::sss_state_type state;
  logic [31:0] tick;
  logic [LAW:0] pos;
  logic str_req;
  logic fifo_push;
  logic fifo_full;
  logic adc_done_s;
  wire tick_end = (tick >= interval - 32'd1) || (interval == 32'd0);
  logic stop_pend;
  wire stop_now = stop_cmd || stop_pend;
  wire [LAW:0] next_pos = pos + (LAW + 1)'(1);
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      state <= sss_pkg::SSS_IDLE;
      running <= 1'b0;
      tick <= 32'd0;
      pos <= '0;
      str_req <= 1'b0;
      res_bad <= 1'b0;
      stop_pend <= 1'b0;
    end else begin
      str_req <= 1'b0;
      // a stop mid-scan waits for the scan to finish
      if (stop_cmd && running) begin
        stop_pend <= 1'b1;
      end
      if (start_cmd) begin
        res_bad <= res_hi;
      end
      if (running && !tick_end) begin
        tick <= tick + 32'd1;
      end else begin
        tick <= 32'd0;
      end
      unique case (state)
        sss_pkg::SSS_IDLE: begin
          if (start_ok) begin
            running <= 1'b1;
            pos <= '0;
            str_req <= 1'b1;
            state <= sss_pkg::SSS_SAMPLE;
            tick <= 32'd0;
          end
        end
        sss_pkg::SSS_WAIT: begin
          if (stop_now) begin
            running <= 1'b0;
            stop_pend <= 1'b0;
            state <= sss_pkg::SSS_IDLE;
          end else if (tick_end) begin
            pos <= '0;
            str_req <= 1'b1;
            state <= sss_pkg::SSS_SAMPLE;
          end
        end
        sss_pkg::SSS_SAMPLE: begin
          if (adc_done_s) begin
            if (next_pos < list_len) begin
              pos <= next_pos;
              str_req <= 1'b1;
            end else if (stop_now) begin
              running <= 1'b0;
              stop_pend <= 1'b0;
              state <= sss_pkg::SSS_IDLE;
            end else begin
              state <= sss_pkg::SSS_WAIT;
            end
          end
        end
      endcase
    end
  end
  assign adc_done_s = ADC_DONE && running;
  assign fifo_push = adc_done_s && (state == sss_pkg::SSS_SAMPLE);

  // ****************************************
  // analog access and command reads
  // ****************************************
  sss_adc_if #(.CW(CW), .DW(DW)) adc ();
  wire [CW-1:0] str_chan = list_mem[pos[LAW-1:0]];
  wire [CW-1:0] cr_chan = HWDATA[CW-1:0];
  sss_arbiter #(.CW(CW), .DW(DW)) u_arb (
    .clk(CLK),
    .reset_n(RESET_N),
    .running(running),
    .str_req(str_req),
    .str_chan(str_chan),
    .cr_req(cr_req),
    .cr_chan(cr_chan),
    .cr_refused(cr_refused),
    .adc(adc.master)
  );
  assign ADC_REQ = adc.req;
  assign ADC_CHAN = adc.chan;
  assign adc.busy = ADC_BUSY;
  assign adc.done = ADC_DONE;
  assign adc.data = ADC_DATA;
  assign cr_req = w_cr;
  logic cr_wait;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cr_wait <= 1'b0;
      cr_done <= 1'b0;
      cr_data <= '0;
      refused <= 1'b0;
    end else begin
      if (cr_req && !running) begin
        cr_wait <= 1'b1;
      end else if (cr_wait && ADC_DONE) begin
        cr_wait <= 1'b0;
      end
      // a finishing conversion still reports when a new one starts
      if (cr_wait && ADC_DONE) begin
        cr_done <= 1'b1;
        cr_data <= ADC_DATA;
      end else if (cr_req && !running) begin
        cr_done <= 1'b0;
      end
      if (cr_refused) begin
        refused <= 1'b1;
      end else if (w_cr) begin
        refused <= 1'b0;
      end
    end
  end

  // ****************************************
  // sample buffer
  // ****************************************
  logic [DW-1:0] fifo_mem [FIFO_DEPTH];
  logic [FAW-1:0] wp;
  logic [FAW-1:0] rp;
  logic [FAW:0] count;
  assign fifo_full = (count == (FAW + 1)'(FIFO_DEPTH));
  wire fifo_empty = (count == '0);
  wire do_push = fifo_push && !fifo_full;
  wire do_pop = r_fifo && !fifo_empty;
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wp <= '0;
      rp <= '0;
      count <= '0;
      overflow <= 1'b0;
    end else begin
      if (do_push) begin
        wp <= wp + FAW'(1);
      end
      if (do_pop) begin
        rp <= rp + FAW'(1);
      end
      count <= count + (FAW + 1)'(do_push) - (FAW + 1)'(do_pop);
      if (fifo_push && fifo_full) begin
        overflow <= 1'b1;
      end else if (clr_ovf) begin
        overflow <= 1'b0;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (do_push) begin
      fifo_mem[wp] <= ADC_DATA;
    end
  end

  // ****************************************
  // read data
  // ****************************************
  wire [31:0] status = 32'({cr_done, res_bad, refused, overflow, running});
  wire [31:0] sample_word = {16'(cr_data), sample_lo};
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sample_lo <= 16'h0000;
    end else begin
      sample_lo <= 16'(status);
    end
  end
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit(pend_addr, sss_pkg::ADDR_STATUS)) begin
      rdata = status;
    end else if (hit(pend_addr, sss_pkg::ADDR_INTERVAL)) begin
      rdata = interval;
    end else if (hit(pend_addr, sss_pkg::ADDR_LIST_LEN)) begin
      rdata = 32'(list_len);
    end else if (hit(pend_addr, sss_pkg::ADDR_RES)) begin
      rdata = 32'(res_index);
    end else if (hit(pend_addr, sss_pkg::ADDR_FIFO_DATA)) begin
      rdata = fifo_empty ? sss_pkg::ERR_WORD : 32'(fifo_mem[rp]);
    end else if (hit(pend_addr, sss_pkg::ADDR_FIFO_COUNT)) begin
      rdata = 32'(count);
    end else if (hit(pend_addr, sss_pkg::ADDR_CR_DATA)) begin
      rdata = 32'(cr_data);
    end else if (hit(pend_addr, sss_pkg::ADDR_SAMPLE_WORD)) begin
      rdata = sample_word;
    end else if (in_list) begin
      rdata = 32'(list_mem[list_idx]);
    end
  end
  assign HRDATA = rd_pend ? rdata : 32'h0000_0000;
endmodule

// *** sim/sss_properties.sv ***
// Purpose: port checks for the scan stream sequencer
// Assumes: the analog model answers four cycles after each request
// Notes: bound to sss_top from the testbench top file
`timescale 1ns/10ps
module sss_properties #(parameter int LIST_DEPTH = 16) (
  input wire CLK,
  input wire RESET_N,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  input wire ADC_REQ,
  input wire ADC_DONE
);
  // ****************************************
  // helper state
  // ****************************************
  logic rd_phase;
  logic rd_unmapped;
  logic armed;
  wire take = HSEL && HREADY && HTRANS[1];
  wire hole = HADDR > 32'h0000_0024 && HADDR < 32'h0000_0100;
  wire tail = HADDR >= 32'h0000_0100 + 32'(4 * LIST_DEPTH) && HADDR < 32'h0001_0000;
  wire kick = take && HWRITE && (HADDR == 32'h0000_0000 || HADDR == 32'h0000_001C);
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rd_phase <= 1'b0;
      rd_unmapped <= 1'b0;
      armed <= 1'b0;
    end else begin
      rd_phase <= take && !HWRITE;
      rd_unmapped <= take && !HWRITE && (hole || tail);
      armed <= armed || kick;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ****************************************
  // assertions
  // ****************************************
  a_ready_always: assert property (HREADYOUT)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!HRESP)
    else $error("slave answered with an error response");
  a_rdata_idle: assert property (!rd_phase |-> HRDATA == 32'h0000_0000)
    else $error("read data driven outside a read data phase");
  a_unmapped_zero: assert property (rd_unmapped |-> HRDATA == 32'h0000_0000)
    else $error("unmapped read returned non-zero");
  a_reset_quiet: assert property (disable iff (1'b0) !RESET_N |=> !ADC_REQ)
    else $error("conversion requested out of reset");
  a_idle_until_cmd: assert property (!armed |-> !ADC_REQ)
    else $error("conversion requested before any command");
  a_req_spacing: assert property (ADC_REQ |=> !ADC_REQ [*4])
    else $error("second request while a conversion is in flight");
  a_req_after_done: assert property (ADC_DONE |-> !ADC_REQ)
    else $error("request raised in the cycle of a done pulse");
endmodule

// *** sim/sss_adc_model.sv ***
// Purpose: behavioural analog input system behind the sequencer
// Assumes: one conversion at a time, fixed latency
// Notes: data toggles when not valid so stale values never match
`timescale 1ns/10ps
module sss_adc_model #(parameter int CW = 8, parameter int DW = 16, parameter int LAT = 4) (
  input wire clk,
  input wire reset_n,
  input wire req,
  input wire [CW-1:0] chan,
  output logic busy,
  output logic done,
  output logic [DW-1:0] data
);
  logic [3:0] cnt;
  logic [CW-1:0] held;
  assign busy = cnt != 4'h0;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      done <= 1'b0;
      data <= '0;
    end else begin
      done <= cnt == 4'h1;
      data <= (cnt == 4'h1) ? DW'({8'hA5, held}) : ~data;
      if (req) begin
        cnt <= 4'(LAT);
        held <= chan;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// *** sim/sss_top_tb.sv ***
// Purpose: register-level tests of the scan stream sequencer
// Assumes: zero-wait AHB-Lite slave, model latency of four cycles
// Notes: a small buffer depth forces overflow quickly
`timescale 1ns/10ps
module sss_top_tb;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0000_0000;
  logic [1:0] HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0000_0000;
  wire HREADY;
  wire [31:0] HRDATA;
  wire HREADYOUT;
  wire HRESP;
  wire ADC_REQ;
  wire [7:0] ADC_CHAN;
  wire ADC_BUSY;
  wire ADC_DONE;
  wire [15:0] ADC_DATA;
  int fails = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [31:0] rd_q;
  logic rdy_q;
  time req_t[$];
  logic [7:0] req_c[$];
  assign HREADY = HREADYOUT;
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    rd_q <= HRDATA;
    rdy_q <= HREADYOUT;
    if (ADC_REQ === 1'b1) begin
      req_t.push_back($time);
      req_c.push_back(ADC_CHAN);
    end
  end
  sss_top #(.FIFO_DEPTH(8)) DUT (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA), .HREADY(HREADY),
    .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ADC_REQ(ADC_REQ),
    .ADC_CHAN(ADC_CHAN), .ADC_BUSY(ADC_BUSY), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA));
  sss_adc_model adc (.clk(CLK), .reset_n(RESET_N), .req(ADC_REQ), .chan(ADC_CHAN),
    .busy(ADC_BUSY), .done(ADC_DONE), .data(ADC_DATA));
  // ****************************************
  // bus and checking tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("counts: %0d checked, %0d fails", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_ready();
    int n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (rdy_q !== 1'b1 && n < 50);
    if (rdy_q !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HWRITE <= wr;
    HADDR <= {16'h0000, a};
    wait_ready();
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    wait_ready();
    rd = rd_q;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd & m, exp);
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    int n;
    repeat (6) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    #1;
    rdchk(sss_pkg::ADDR_STATUS, 32'h0000_0000, '1);
    rdchk(sss_pkg::ADDR_INTERVAL, sss_pkg::INTERVAL_RESET, '1);
    xfer(1'b1, 16'h0040, 32'h1234_5678);
    rdchk(16'h0040, 32'h0000_0000, '1);
    xfer(1'b1, sss_pkg::ADDR_LIST_LEN, 32'h0000_0003);
    for (n = 0; n < 3; n++) xfer(1'b1, 16'(sss_pkg::ADDR_LIST_BASE + 4 * n), 32'(5 + n));
    xfer(1'b1, sss_pkg::ADDR_INTERVAL, 32'h0000_0028);
    rdchk(sss_pkg::ADDR_LIST_LEN, 32'h0000_0003, '1);
    rdchk(16'(sss_pkg::ADDR_LIST_BASE + 8), 32'h0000_0007, '1);
    $display("test map done");
    for (n = 9; n <= 12; n++) begin
      xfer(1'b1, sss_pkg::ADDR_RES, 32'(n));
      xfer(1'b1, sss_pkg::ADDR_CTRL, 32'h0000_0001);
      rdchk(sss_pkg::ADDR_STATUS, 32'h0000_0008, 32'h0000_0009);
    end
    xfer(1'b1, sss_pkg::ADDR_RES, 32'h0000_0000);
    $display("test resolution done");
    req_t.delete();
    req_c.delete();
    xfer(1'b1, sss_pkg::ADDR_CTRL, 32'h0000_0001);
    rdchk(sss_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001);
    xfer(1'b1, sss_pkg::ADDR_CR_CHAN, 32'h0000_0002);
    rdchk(sss_pkg::ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
    xfer(1'b1, sss_pkg::ADDR_INTERVAL, 32'h0000_0063);
    rdchk(sss_pkg::ADDR_INTERVAL, 32'h0000_0028, '1);
    repeat (150) @(posedge CLK);
    #1;
    xfer(1'b1, sss_pkg::ADDR_CTRL, 32'h0000_0002);
    repeat (60) @(posedge CLK);
    #1;
    rdchk(sss_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0001);
    check(32'(req_c.size() > 8), 32'h0000_0001);
    check(32'(req_c.size() % 3), 32'h0000_0000);
    for (n = 0; n < req_c.size(); n++) check({24'h0, req_c[n]}, 32'(5 + n % 3));
    check(32'(req_t[3] - req_t[0]), 32'(40 * 20));
    check(32'(req_t[1] - req_t[0]), 32'(6 * 20));
    $display("test stream done");
    rdchk(sss_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0000_0002);
    rdchk(sss_pkg::ADDR_FIFO_COUNT, 32'h0000_0008, '1);
    for (n = 0; n < 8; n++) rdchk(sss_pkg::ADDR_FIFO_DATA, 32'(16'hA505 + n % 3), 32'h0000_FFFF);
    rdchk(sss_pkg::ADDR_FIFO_DATA, sss_pkg::ERR_WORD, '1);
    rdchk(sss_pkg::ADDR_FIFO_COUNT, 32'h0000_0000, '1);
    xfer(1'b1, sss_pkg::ADDR_CTRL, 32'h0000_0004);
    rdchk(sss_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_0002);
    $display("test buffer done");
    xfer(1'b1, sss_pkg::ADDR_CR_CHAN, 32'h0000_0003);
    n = 0;
    do begin
      xfer(1'b0, sss_pkg::ADDR_STATUS, 32'h0000_0000);
      n++;
    end while (rd[4] !== 1'b1 && n < 20);
    if (rd[4] !== 1'b1) begin
      fails++;
      tally_and_finish();
    end
    rdchk(sss_pkg::ADDR_CR_DATA, 32'h0000_A503, 32'h0000_FFFF);
    rdchk(sss_pkg::ADDR_SAMPLE_WORD, 32'hA503_0010, '1);
    $display("test command read done");
    tally_and_finish();
  end
endmodule
bind sss_top sss_properties #(.LIST_DEPTH(LIST_DEPTH)) chk (.CLK(CLK), .RESET_N(RESET_N),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ADC_REQ(ADC_REQ),
  .ADC_DONE(ADC_DONE));
